// [hdl/sacc_defines.vh]
/*
 * shared constants for the sample/convert control block: register
 * offsets, field positions, reset values and timing counts.
 * assumes inclusion by bare name from the design file only.
 */
`ifndef SACC_DEFINES_VH
`define SACC_DEFINES_VH

// register byte offsets on the apb bus
`define SACC_OFF_CTRL0    12'h000
`define SACC_OFF_CTRL1    12'h004
`define SACC_OFF_STATUS   12'h008
`define SACC_OFF_FLAGS    12'h00c
`define SACC_OFF_PINSEL   12'h010
`define SACC_OFF_ENTRY    12'h014
`define SACC_OFF_DATAIN   12'h018
`define SACC_OFF_MEM_BASE 12'h040

// ctrl0 fields
`define SACC_C0_ENABLE    0
`define SACC_C0_START     1
`define SACC_C0_CORE_ON   4
`define SACC_C0_REF_ON    5
`define SACC_C0_REF_LVL   6
`define SACC_C0_SHT0_LSB  8
`define SACC_C0_SHT1_LSB  12

// ctrl1 fields
`define SACC_C1_SRC_LSB   0
`define SACC_C1_DIV_LSB   2
`define SACC_C1_MODE      5
`define SACC_C1_INV       6
`define SACC_C1_TRG_LSB   8
`define SACC_C1_CHAN_LSB  12

// reset values
`define SACC_CTRL0_RST    32'h0000_0000
`define SACC_CTRL1_RST    32'h0000_0000

// timing
`define SACC_CONV_CYCLES  4'hd
`define SACC_FULL_SCALE   12'hfff

`endif

// [hdl/sacc_sample_convert.v]
/*
 * sample and convert control of a 12-bit successive-approximation
 * converter: clock select/divide, trigger select, sampling window,
 * 13-cycle conversion, result store and auto power-down.
 * assumes: apb master on clock_i; the four source clocks arrive as
 * asynchronous square waves and are sampled; comparator_i is the
 * analog comparator output; it is synchronised here, so conv ticks
 * must be at least four clock_i cycles apart for a trial to settle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sacc_defines.vh"

// What this block does
// - result saturates at all ones or zero
// - ctrl0, ctrl1 and entry writes ignored while enable set, except enable, start and reference on
// - no conversion while enable is clear
// - conv clock from four sources, divide 1-8
// - one conv clock steps conversion and timer
// - one of twelve channels selected, none for codes 12-15
// - analog select kills pin buffers
// - reference on and level select outputs
// - core and oscillator power only when busy
// - reference never switched off automatically
// - trigger rising edge starts sampling
// - trigger from four selectable sources
// - optional trigger polarity inversion
// - sample while high, then 13 cycles
// - extended mode: trigger drives sample control
// - pulse mode: timer holds sample control
// - sample time in fours of clocks
// - field by entry 0-7 or 8-15
// - sixteen word result buffer
// - vector register gives highest pending source
// - result write sets slot flag
module sacc_sample_convert #(
    parameter NUM_SLOTS = 16
) (
    // clock and reset
    input  wire        clock_i,
    input  wire        rst_n_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    // clock sources, asynchronous
    input  wire        subsystem_clock_i,
    input  wire        main_clock_i,
    input  wire        aux_clock_i,
    input  wire        internal_conv_oscillator_i,
    // timer trigger outputs, asynchronous
    input  wire        timer_a_out1_i,
    input  wire        timer_b_out0_i,
    input  wire        timer_b_out1_i,
    // analog core
    input  wire        comparator_i,
    output reg  [11:0] dac_o,
    output reg         sample_control_o,
    output reg         core_power_o,
    output reg         osc_enable_o,
    output reg         reference_on_o,
    output reg         reference_level_sel_o,
    output reg  [11:0] channel_onehot_o,
    // port pins
    output reg  [7:0]  pin_buffer_disable_o,
    // status
    output reg         busy_o
);

    // fsm states, one-hot
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_SAMP = 4'b0010;
    localparam [3:0] ST_CONV = 4'b0100;
    localparam [3:0] ST_STOR = 4'b1000;

    // registers
    reg [31:0] ctrl0_reg;                 // enable, start, power, times
    reg [31:0] ctrl1_reg;                 // clock, trigger, mode, channel
    reg [7:0]  pinsel_reg;                // analog select per pin
    reg [3:0]  entry_reg;                 // control entry in use
    reg [11:0] datain_reg;                // test hook: written and read back only
    reg [11:0] mem [0:NUM_SLOTS-1];       // result slots
    reg [NUM_SLOTS-1:0] flags_reg;        // result flags
    reg [3:0]  state_reg;
    reg [3:0]  bit_cnt_reg;               // conversion step counter
    reg [5:0]  samp_cnt_reg;              // pulse mode sample counter
    reg [11:0] sar_reg;                   // approximation register
    reg [2:0]  div_cnt_reg;               // clock divider
    reg [1:0]  src_sync_reg;              // source clock synchroniser
    reg        src_prev_reg;              // for rising edge detect
    reg [2:0]  trg_sync_reg;              // trigger sync plus history
    reg [1:0]  timer_a1_reg;              // timer a unit 1 synchroniser
    reg [1:0]  timer_b0_reg;              // timer b unit 0 synchroniser
    reg [1:0]  timer_b1_reg;              // timer b unit 1 synchroniser
    reg [1:0]  comp_sync_reg;             // comparator synchroniser

    // decode
    wire enable     = ctrl0_reg[`SACC_C0_ENABLE];
    wire sw_start   = ctrl0_reg[`SACC_C0_START];
    wire [1:0] src  = ctrl1_reg[`SACC_C1_SRC_LSB +: 2];
    wire [2:0] div  = ctrl1_reg[`SACC_C1_DIV_LSB +: 3];
    wire pulse_mode = ctrl1_reg[`SACC_C1_MODE];
    wire invert     = ctrl1_reg[`SACC_C1_INV];
    wire [1:0] trg  = ctrl1_reg[`SACC_C1_TRG_LSB +: 2];
    wire [3:0] chan = ctrl1_reg[`SACC_C1_CHAN_LSB +: 4];
    wire [3:0] sht0 = ctrl0_reg[`SACC_C0_SHT0_LSB +: 4];
    wire [3:0] sht1 = ctrl0_reg[`SACC_C0_SHT1_LSB +: 4];

    // writes land at the access edge; the slave answers at once, so
    // a read returns what the registers held before that edge
    wire wr_en = psel_i & penable_i & pwrite_i;
    wire idle  = state_reg[0];

    // conversion clock source select; the selected raw clock goes through
    // two flops so the divider sees a clean level, which caps the usable
    // source rate near a third of clock_i
    reg  src_raw;
    always @* begin
        case (src)
            2'd0:    src_raw = internal_conv_oscillator_i;
            2'd1:    src_raw = aux_clock_i;
            2'd2:    src_raw = main_clock_i;
            default: src_raw = subsystem_clock_i;
        endcase
    end

    wire src_rise = src_sync_reg[1] & ~src_prev_reg;
    wire conv_tick = src_rise && (div_cnt_reg == div);

    // source sync, edge detect and divider
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_sync_reg <= 2'b00;
            src_prev_reg <= 1'b0;
            div_cnt_reg  <= 3'd0;
        end else begin
            src_sync_reg <= {src_sync_reg[0], src_raw};
            src_prev_reg <= src_sync_reg[1];
            if (src_rise) begin
                if (div_cnt_reg == div)
                    div_cnt_reg <= 3'd0;
                else
                    div_cnt_reg <= div_cnt_reg + 3'd1;
            end
        end
    end

    // timer outputs: two flops each in the fast domain first
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_a1_reg <= 2'b00;
            timer_b0_reg <= 2'b00;
            timer_b1_reg <= 2'b00;
        end else begin
            timer_a1_reg <= {timer_a1_reg[0], timer_a_out1_i};
            timer_b0_reg <= {timer_b0_reg[0], timer_b_out0_i};
            timer_b1_reg <= {timer_b1_reg[0], timer_b_out1_i};
        end
    end

    // analog comparator: two flops before the sar logic reads it; with
    // the dac_o flop this needs conv ticks four clocks apart
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            comp_sync_reg <= 2'b00;
        else
            comp_sync_reg <= {comp_sync_reg[0], comparator_i};
    end
    wire comp_level = comp_sync_reg[1];   // settled trial answer

    // software start is a level: it must be cleared and set again to
    // give the next rising edge
    // trigger source mux and polarity
    reg trg_raw;
    always @* begin
        case (trg)
            2'd0:    trg_raw = sw_start;
            2'd1:    trg_raw = timer_a1_reg[1];
            2'd2:    trg_raw = timer_b0_reg[1];
            default: trg_raw = timer_b1_reg[1];
        endcase
    end
    wire sample_trigger = trg_raw ^ invert;

    // two more stages on conv ticks, third stage is edge history
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            trg_sync_reg <= 3'b000;
        else if (conv_tick)
            trg_sync_reg <= {trg_sync_reg[1:0], sample_trigger};
    end
    wire trg_level = trg_sync_reg[1];
    wire trg_rise  = trg_sync_reg[1] & ~trg_sync_reg[2];

    // sample time: 4 * (field + 1) conv clocks, field by entry
    wire [3:0] sht_sel = entry_reg[3] ? sht1 : sht0;
    wire [5:0] samp_len = {sht_sel, 2'b11};

    // sequencer
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg        <= ST_IDLE;
            bit_cnt_reg      <= 4'd0;
            samp_cnt_reg     <= 6'd0;
            sar_reg          <= 12'h000;
            sample_control_o <= 1'b0;
        end else if (!enable) begin
            // clearing enable aborts at once; result is lost
            state_reg        <= ST_IDLE;
            sample_control_o <= 1'b0;
        end else if (conv_tick) begin
            case (state_reg)
                ST_IDLE: begin
                    if (trg_rise) begin
                        state_reg        <= ST_SAMP;
                        sample_control_o <= 1'b1;
                        samp_cnt_reg     <= samp_len;
                    end
                end
                ST_SAMP: begin
                    if (pulse_mode ? (samp_cnt_reg == 6'd0)
                                   : !trg_level) begin
                        state_reg        <= ST_CONV;
                        sample_control_o <= 1'b0;
                        bit_cnt_reg      <= 4'd0;
                        sar_reg          <= 12'h800;
                    end else begin
                        samp_cnt_reg <= samp_cnt_reg - 6'd1;
                    end
                end
                ST_CONV: begin
                    // 12 bit trials then one settle cycle: 13 in total
                    if (bit_cnt_reg == `SACC_CONV_CYCLES - 4'd1) begin
                        state_reg <= ST_STOR;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 4'd1;
                        if (bit_cnt_reg < 4'd12) begin
                            // input at or above top keeps all ones,
                            // at or below bottom ends at zero
                            sar_reg <= sar_reg
                                & ~((comp_level ? 12'h000 : 12'h800)
                                    >> bit_cnt_reg)
                                | ((12'h800 >> bit_cnt_reg) >> 1);
                        end
                    end
                end
                ST_STOR: begin
                    // the slot logic below writes the result on this tick
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // result store and slot flags; hardware set wins over software clear
    wire store = enable & conv_tick & state_reg[3];
    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g = g + 1) begin : g_slot
            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    mem[g]       <= 12'h000;
                    flags_reg[g] <= 1'b0;
                end else if (store && entry_reg == g) begin
                    mem[g]       <= sar_reg & `SACC_FULL_SCALE;
                    flags_reg[g] <= 1'b1;
                end else if (wr_en && paddr_i == `SACC_OFF_FLAGS
                             && pwdata_i[g]) begin
                    flags_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // register writes; most fields locked while enable is set
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl0_reg  <= `SACC_CTRL0_RST;
            ctrl1_reg  <= `SACC_CTRL1_RST;
            pinsel_reg <= 8'h00;
            entry_reg  <= 4'h0;
            datain_reg <= 12'h000;
        end else if (wr_en) begin
            case (paddr_i)
                `SACC_OFF_CTRL0: begin
                    if (!enable)
                        ctrl0_reg <= pwdata_i;
                    else begin
                        // enable, start and reference stay writable
                        ctrl0_reg[`SACC_C0_ENABLE] <= pwdata_i[0];
                        ctrl0_reg[`SACC_C0_START]  <= pwdata_i[1];
                        ctrl0_reg[`SACC_C0_REF_ON] <= pwdata_i[5];
                    end
                end
                `SACC_OFF_CTRL1:
                    if (!enable) ctrl1_reg <= pwdata_i;
                `SACC_OFF_PINSEL: pinsel_reg <= pwdata_i[7:0];
                `SACC_OFF_ENTRY:
                    if (!enable) entry_reg <= pwdata_i[3:0];
                `SACC_OFF_DATAIN: datain_reg <= pwdata_i[11:0];
                default: ;
            endcase
        end
    end

    // everything leaves through a flop, one clock after the state it
    // follows, so busy trails sample control by one clock
    // analog side outputs
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_power_o          <= 1'b0;
            osc_enable_o          <= 1'b0;
            reference_on_o        <= 1'b0;
            reference_level_sel_o <= 1'b0;
            channel_onehot_o      <= 12'h000;
            pin_buffer_disable_o  <= 8'h00;
            busy_o                <= 1'b0;
            dac_o                 <= 12'h000;
        end else begin
            // power only while a conversion is in flight
            core_power_o <= ctrl0_reg[`SACC_C0_CORE_ON] & ~idle;
            osc_enable_o <= ~idle && src == 2'd0;
            reference_on_o        <= ctrl0_reg[`SACC_C0_REF_ON];
            reference_level_sel_o <= ctrl0_reg[`SACC_C0_REF_LVL];
            channel_onehot_o <= (chan < 4'd12)
                ? (12'h001 << chan) : 12'h000;
            pin_buffer_disable_o <= pinsel_reg;
            busy_o <= ~idle;
            dac_o  <= sar_reg;
        end
    end

    // highest pending flag: lowest slot number wins, 0 means none
    // a new flag may change the vector between two reads of status
    reg [4:0] vector;
    integer k;
    always @* begin
        vector = 5'd0;
        for (k = NUM_SLOTS - 1; k >= 0; k = k - 1)
            if (flags_reg[k]) vector = k[4:0] + 5'd1;
    end

    // apb read mux, zero-wait
    reg [31:0] rdata;
    always @* begin
        rdata = 32'h0000_0000;
        case (paddr_i)
            `SACC_OFF_CTRL0:  rdata = ctrl0_reg;
            `SACC_OFF_CTRL1:  rdata = ctrl1_reg;
            `SACC_OFF_STATUS: rdata = {23'h0, vector, state_reg[3:1], busy_o};
            `SACC_OFF_FLAGS:  rdata = {{(32-NUM_SLOTS){1'b0}}, flags_reg};
            `SACC_OFF_PINSEL: rdata = {24'h0, pinsel_reg};
            `SACC_OFF_ENTRY:  rdata = {28'h0, entry_reg};
            `SACC_OFF_DATAIN: rdata = {20'h0, datain_reg};
            default:
                if (paddr_i[11:6] == 6'h01)
                    rdata = {20'h0, mem[paddr_i[5:2]]};
        endcase
    end

    // no wait states and no error answer: every offset is legal and
    // unmapped reads return zero
    assign prdata_o  = rdata;
    assign pready_o  = 1'b1;
    assign pslverr_o = 1'b0;

endmodule // sacc_sample_convert
`default_nettype wire

// [tb/sacc_sample_convert_sva.sv]
/* port checker for sacc_sample_convert: apb answer, sampling, busy,
   power and pin timing. assumes clock_i only, async low reset. */
`timescale 1ns/1ps
`default_nettype none
module sacc_sample_convert_sva (
    // clock and reset
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    // apb handshake
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // converter outputs
    input wire logic        sample_control_o,
    input wire logic        busy_o,
    input wire logic        core_power_o,
    input wire logic        osc_enable_o,
    input wire logic        reference_on_o,
    input wire logic [11:0] channel_onehot_o,
    input wire logic [7:0]  pin_buffer_disable_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire wr_w = psel_i & penable_i & pwrite_i; // write taken this edge
    // sampling ends into a conversion, not an abort by software
    sequence conv_go_s;
        $fell(sample_control_o) && busy_o && !$past(wr_w) && !$past(wr_w, 2);
    endsequence
    // no software write for eight edges
    sequence quiet_s;
        (!wr_w)[*8];
    endsequence
    AST_APB_NOWAIT: assert property (psel_i && penable_i |->
        pready_o && !pslverr_o) else $error("apb access not answered");
    AST_BUSY_FOLLOWS: assert property ($rose(sample_control_o) |=> busy_o)
        else $error("busy late after sampling");
    AST_CONV_HOLDS: assert property (conv_go_s ##1 quiet_s |-> busy_o)
        else $error("conversion ended too soon");
    AST_CORE_OFF: assert property ($fell(busy_o) |-> ##[0:2] !core_power_o)
        else $error("core left powered when idle");
    AST_OSC_OFF: assert property ($fell(busy_o) |-> ##[0:2] !osc_enable_o)
        else $error("oscillator left on when idle");
    AST_CORE_ON: assert property ($rose(busy_o) |-> ##[0:1] core_power_o)
        else $error("core not powered for conversion");
    AST_REF_HOLD: assert property ($fell(reference_on_o) |->
        $past(wr_w) || $past(wr_w, 2))
        else $error("reference dropped without a write");
    AST_PIN_HOLD: assert property (!$stable(pin_buffer_disable_o) |->
        $past(wr_w) || $past(wr_w, 2))
        else $error("pin buffers changed without a write");
    AST_ONE_CHAN: assert property (sample_control_o |->
        $onehot(channel_onehot_o))
        else $error("not exactly one channel while sampling");
endmodule // sacc_sample_convert_sva
bind sacc_sample_convert sacc_sample_convert_sva sacc_sample_convert_sva_i (
    .clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .pready_o,
    .pslverr_o, .sample_control_o, .busy_o, .core_power_o, .osc_enable_o,
    .reference_on_o, .channel_onehot_o, .pin_buffer_disable_o);
`default_nettype wire

// [tb/sacc_analog_model.sv]
/* analog side model: ideal comparator and four source clocks.
   assumes rising clock_i edges at odd multiples of 50 ns. */
`timescale 1ns/1ps
`default_nettype none
module sacc_analog_model (
    // analog core
    input  wire logic [11:0] dac_i,
    input  wire logic [12:0] vin_i,
    output var  logic        comparator_o,
    // source clocks, all below a third of clock_i
    output var  logic        osc_o,
    output var  logic        aux_o,
    output var  logic        main_o,
    output var  logic        sub_o
);
    // toggles land between rising clock_i edges, so no sampling race
    initial begin
        {osc_o, aux_o, main_o, sub_o} = 4'h0;
    end
    always #200 osc_o = ~osc_o;
    always #300 aux_o = ~aux_o;
    always #400 main_o = ~main_o;
    always #500 sub_o = ~sub_o;
    // inputs above full scale keep answering one
    always_comb comparator_o = (vin_i >= {1'b0, dac_i});
endmodule // sacc_analog_model
`default_nettype wire

// [tb/sacc_sample_convert_tb.sv]
/* self-checking bench for sacc_sample_convert over apb.
   assumes zero-wait apb and the analog model on the far side. */
`timescale 1ns/1ps
`default_nettype none
module sacc_sample_convert_tb;
    logic        clock_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0;
    logic        pwrite_i = 0, pready_o, pslverr_o, comparator_i;
    logic [11:0] paddr_i = 0, dac_o, channel_onehot_o;
    logic [31:0] pwdata_i = 0, prdata_o;
    logic [2:0]  tmr = 0; // timer trigger levels
    logic [12:0] vin = 0; // analog input level
    logic        subsystem_clock_i, main_clock_i, aux_clock_i;
    logic        internal_conv_oscillator_i, sample_control_o, busy_o;
    logic        core_power_o, osc_enable_o, reference_on_o;
    logic        reference_level_sel_o;
    logic [7:0]  pin_buffer_disable_o;
    int          fail_count = 0, checks = 0;
    int          sc_n = 0, samp_len = 0, cv_n = 0, conv_len = 0;
    always #50 clock_i = ~clock_i;
    sacc_sample_convert sacc_sample_convert_i (.clock_i, .rst_n_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .subsystem_clock_i, .main_clock_i, .aux_clock_i,
        .internal_conv_oscillator_i, .timer_a_out1_i(tmr[0]),
        .timer_b_out0_i(tmr[1]), .timer_b_out1_i(tmr[2]), .comparator_i,
        .dac_o, .sample_control_o, .core_power_o, .osc_enable_o,
        .reference_on_o, .reference_level_sel_o, .channel_onehot_o,
        .pin_buffer_disable_o, .busy_o);
    sacc_analog_model sacc_analog_model_i (.dac_i(dac_o), .vin_i(vin),
        .comparator_o(comparator_i), .osc_o(internal_conv_oscillator_i),
        .aux_o(aux_clock_i), .main_o(main_clock_i),
        .sub_o(subsystem_clock_i));
    // lengths of the last sampling window and conversion, in clocks
    always @(posedge clock_i) begin
        if (sample_control_o) sc_n <= sc_n + 1;
        else if (sc_n != 0) begin samp_len <= sc_n; sc_n <= 0; end
        if (busy_o && !sample_control_o) cv_n <= cv_n + 1;
        else if (cv_n != 0) begin conv_len <= cv_n; cv_n <= 0; end
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_rng(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    // one apb transfer; request held until pready seen at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1;
        @(posedge clock_i);
        for (n = 0; pready_o !== 1'b1; n++) begin
            if (n == 20) begin fail_count++; end_of_test(); end
            @(posedge clock_i);
        end
        r = prdata_o;
        psel_i <= 0; penable_i <= 0;
        @(posedge clock_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        cmp(r, exp);
    endtask
    task automatic wait_busy(input logic lvl);
        int n;
        for (n = 0; busy_o !== lvl; n++) begin
            if (n == 3000) begin fail_count++; end_of_test(); end
            @(posedge clock_i);
        end
    endtask
    // one run: sht0 0, sht1 1, core and reference on; k picks trigger
    task automatic conv(input logic [31:0] c1, input logic [3:0] ent,
                        input int k, input int hold);
        tmr <= {3{c1[6]}};
        // ideal model reference is settled at once, so no wait here
        wr(12'h000, 32'h1030);
        wr(12'h004, c1);
        wr(12'h014, {28'h0, ent});
        wr(12'h00c, 32'hffff);
        wr(12'h000, 32'h1031);
        if (k == 0) wr(12'h000, 32'h1033);
        else begin
            tmr <= {3{c1[6]}} ^ (3'b001 << (k - 1));
            repeat (hold) @(posedge clock_i);
            tmr <= {3{c1[6]}};
        end
        wait_busy(1'b1);
        @(posedge clock_i);
        cmp({30'h0, core_power_o, osc_enable_o},
            {30'h0, 1'b1, c1[1:0] == 2'd0});
        wait_busy(1'b0);
        repeat (2) @(posedge clock_i);
    endtask
    task automatic t_regs;
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        rd(12'h0fc, 32'h0);
        wr(12'h000, 32'h60);
        @(posedge clock_i); // outputs follow the write by one clock
        cmp({30'h0, reference_on_o, reference_level_sel_o}, 32'h3);
        wr(12'h000, 32'h20);
        @(posedge clock_i);
        cmp({30'h0, reference_on_o, reference_level_sel_o}, 32'h2);
        wr(12'h010, 32'ha5);
        @(posedge clock_i);
        cmp({24'h0, pin_buffer_disable_o}, 32'ha5);
        wr(12'h004, 32'hb000);
        @(posedge clock_i);
        cmp({20'h0, channel_onehot_o}, 32'h800);
        $display("test regs done");
    endtask
    task automatic t_lock;
        wr(12'h004, 32'h20);
        wr(12'h000, 32'h1012);
        repeat (60) @(posedge clock_i);
        cmp({31'h0, busy_o}, 32'h0);
        wr(12'h000, 32'h1011);
        wr(12'h004, 32'hffff);
        rd(12'h004, 32'h20);
        wr(12'h000, 32'h0);
        $display("test lock done");
    endtask
    task automatic t_convert;
        vin <= 13'h1fff;
        conv(32'h20, 4'h0, 0, 0);
        cmp_rng(samp_len, 15, 17);
        rd(12'h040, 32'hfff);
        rd(12'h00c, 32'h1);
        rd(12'h008, 32'h10);
        cmp({29'h0, core_power_o, osc_enable_o, reference_on_o}, 32'h1);
        vin <= 13'h0;
        conv(32'h20, 4'h8, 0, 0);
        cmp_rng(samp_len, 31, 33);
        rd(12'h060, 32'h0);
        rd(12'h00c, 32'h100);
        rd(12'h008, 32'h90);
        vin <= 13'h5a3;
        conv(32'h20, 4'hf, 0, 0);
        rd(12'h07c, 32'h5a3);
        conv(32'h100, 4'h0, 1, 40);
        cmp_rng(samp_len, 32, 48);
        $display("test convert done");
    endtask
    // every clock source and trigger, divides 2, 4, 6 and 8, odd ones inverted
    task automatic t_sources;
        int k, t;
        for (k = 0; k < 4; k++) begin
            t = (4 + 2 * k) * (2 * k + 2);
            conv(k | ((2 * k + 1) << 2) | 32'h20 | (k << 8) | ((k % 2) << 6),
                 4'h0, k, 3 * t);
            cmp_rng(samp_len, 4 * t - 1, 4 * t + 1);
            cmp_rng(conv_len, 13 * t + 1, 15 * t - 1);
        end
        $display("test sources done");
    endtask
    initial begin
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1;
        @(posedge clock_i);
        t_regs();
        t_lock();
        t_convert();
        t_sources();
        end_of_test();
    end
endmodule // sacc_sample_convert_tb
`default_nettype wire
